// ===== inc/fault_pkg.sv
// Shared constants for the loop fault status register and its serial readout
package fault_pkg;
	// ==========================================
	// Fault register layout
	localparam int STATUS_W         = 16;
	localparam int BIT_LINK_LOSS    = 15;
	localparam int BIT_CRC_ERROR    = 14;
	localparam int BIT_CURRENT_HIGH = 13;
	localparam int BIT_CURRENT_LOW  = 12;
	localparam int BIT_TEMP_FAULT   = 11;
	localparam int BIT_TEMP_WARN    = 10;
	localparam int BIT_SUPPLY_6V    = 9;
	localparam int BIT_SUPPLY_12V   = 8;
	localparam int ADC_LSB          = 0;
	localparam int ADC_W            = 8;
	localparam logic [STATUS_W-1:0] STATUS_RESET = 16'h0000;
	// Flags that drive the fault pin; warning and 12 V flags are left out
	localparam logic [STATUS_W-1:0] PIN_SET_MASK = 16'hFA00;
	// ==========================================
	// Comparator input vector positions
	localparam int CMP_W          = 8;
	localparam int CMP_CUR_HIGH   = 0;
	localparam int CMP_CUR_LOW    = 1;
	localparam int CMP_ABOVE_140  = 2;
	localparam int CMP_BELOW_125  = 3;
	localparam int CMP_ABOVE_100  = 4;
	localparam int CMP_BELOW_85   = 5;
	localparam int CMP_SUPPLY_6V  = 6;
	localparam int CMP_SUPPLY_12V = 7;
	// ==========================================
	// Serial readout
	localparam int PUB_W     = STATUS_W + 1;
	localparam int BITCNT_W  = 5;
	localparam logic [BITCNT_W-1:0] BITCNT_LAST = 5'h0F;
	localparam logic [BITCNT_W-1:0] BITCNT_DONE = 5'h10;
	localparam int SYNC_W    = CMP_W + 2;
endpackage

// ===== src/fault_readout.sv
// Serial-clock side: shifts the published fault word out on the data output pin
`timescale 1ns/1ps
module fault_readout (
	input  wire logic                        sclk,
	input  wire logic                        arst_n,
	input  wire logic                        frame_rst_n,
	input  wire logic [fault_pkg::PUB_W-1:0] published,
	output logic                             sdo,
	output logic                             sdo_oe,
	output logic                             done_toggle
);
	import fault_pkg::*;

	// ==========================================
	// Shift engine, held in reset whenever the frame is idle
	logic [BITCNT_W-1:0] bit_cnt;
	logic [STATUS_W-1:0] shreg;

	// Word is stable here: the main clock freezes it while a frame is open
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt <= '0;
			shreg   <= STATUS_RESET;
			sdo     <= 1'b0;
			sdo_oe  <= 1'b0;
		end else if (bit_cnt == '0) begin
			bit_cnt <= bit_cnt + 5'h01;
			shreg   <= {published[STATUS_W-2:0], 1'b0};
			sdo     <= published[STATUS_W-1];
			sdo_oe  <= published[STATUS_W];
		end else if (bit_cnt != BITCNT_DONE) begin
			bit_cnt <= bit_cnt + 5'h01;
			shreg   <= {shreg[STATUS_W-2:0], 1'b0};
			sdo     <= shreg[STATUS_W-1];
		end
	end

	// Toggle survives the frame end, so a stopped clock cannot lose it
	// Only the device reset clears it, in step with the clk side copies
	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			done_toggle <= 1'b0;
		end else if (bit_cnt == BITCNT_LAST && sdo_oe) begin
			done_toggle <= ~done_toggle;
		end
	end

	// ==========================================
	// Checks
	a_sdo_quiet: assert property (@(posedge sclk) disable iff (!frame_rst_n)
		(bit_cnt == '0 && !published[STATUS_W]) |=> !sdo_oe)
		else $error("data output driven with readback off");
	a_sdo_first_bit: assert property (@(posedge sclk) disable iff (!frame_rst_n)
		(bit_cnt == '0 && published[STATUS_W]) |=> (sdo == $past(published[STATUS_W-1]) && sdo_oe))
		else $error("first readback bit wrong");
	c_full_readout: cover property (@(posedge sclk) disable iff (!frame_rst_n)
		sdo_oe && bit_cnt == BITCNT_LAST);
endmodule

// ===== src/fault_status_reg.sv
// Fault status register: flag latching, fault pin, alarm current control, readout crossing
//
// Contract
// - Link timeout sets the link-loss flag and raises the fault pin.
// - Link-loss forces alarm current only while the alarm-disable control bit is 0.
// - Alarm direction pin picks upscale or downscale alarm current.
// - Received-frame CRC error sets the crc error flag and raises the fault pin.
// - Loop current above programmed value sets current-high flag and fault pin.
// - Loop current below programmed value sets current-low flag and fault pin.
// - Over 140C sets temperature fault flag and pin; clears only below 125C.
// - Over 100C sets warning flag, clears below 85C; no fault pin.
// - Supply sense below 0.3 V sets 6 V flag and fault pin.
// - Supply sense below 0.6 V sets 12 V flag; no fault pin.
// - Low byte carries the 8-bit converter result, supply or temperature.
// - With auto readback bit 0, fault register shifts out on every write.
`timescale 1ns/1ps
module fault_status_reg (
	input  wire logic                           clk,
	input  wire logic                           arst_n,
	input  wire logic                           link_timeout,
	input  wire logic                           crc_error,
	input  wire logic [fault_pkg::CMP_W-1:0]    comparators,
	input  wire logic [fault_pkg::ADC_W-1:0]    adc_result,
	input  wire logic                           alarm_disable,
	input  wire logic                           readback_off,
	input  wire logic                           alarm_dir_high,
	input  wire logic                           sclk,
	input  wire logic                           sync_n,
	input  wire logic                           sdi,
	output logic                                sdo,
	output logic                                sdo_oe,
	output logic                                fault_pin,
	output logic                                alarm_force,
	output logic                                alarm_upscale,
	output logic [fault_pkg::STATUS_W-1:0]      fault_status
);
	import fault_pkg::*;

	// ==========================================
	// Helpers
	function automatic logic pin_request(input logic [STATUS_W-1:0] flags);
		return |(flags & PIN_SET_MASK);
	endfunction

	// ==========================================
	// Pin synchronisers
	logic [SYNC_W-1:0] pin_s1;
	logic [SYNC_W-1:0] pin_s2;
	logic [CMP_W-1:0]  cmp;
	logic              frame_open;
	logic              dir_high;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			pin_s1 <= {~sync_n, alarm_dir_high, comparators};
			pin_s2 <= pin_s1;
		end
	end

	assign cmp        = pin_s2[CMP_W-1:0];
	assign dir_high   = pin_s2[CMP_W];
	assign frame_open = pin_s2[CMP_W+1];

	// ==========================================
	// Readout completion crossing, toggle to pulse
	logic done_toggle;
	logic done_s1;
	logic done_s2;
	logic done_s3;
	logic readout_done;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			done_s1 <= 1'b0;
			done_s2 <= 1'b0;
			done_s3 <= 1'b0;
		end else begin
			done_s1 <= done_toggle;
			done_s2 <= done_s1;
			done_s3 <= done_s2;
		end
	end

	assign readout_done = done_s2 ^ done_s3;

	// ==========================================
	// Sticky event flags, cleared once a readout has shifted them out
	// A new event in the clearing cycle wins; one set after the word froze is cleared unread
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_status[BIT_LINK_LOSS] <= STATUS_RESET[BIT_LINK_LOSS];
		end else if (link_timeout) begin
			fault_status[BIT_LINK_LOSS] <= 1'b1;
		end else if (readout_done) begin
			fault_status[BIT_LINK_LOSS] <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_status[BIT_CRC_ERROR] <= STATUS_RESET[BIT_CRC_ERROR];
		end else if (crc_error) begin
			fault_status[BIT_CRC_ERROR] <= 1'b1;
		end else if (readout_done) begin
			fault_status[BIT_CRC_ERROR] <= 1'b0;
		end
	end

	// ==========================================
	// Temperature flags with hysteresis
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_status[BIT_TEMP_FAULT] <= STATUS_RESET[BIT_TEMP_FAULT];
		end else if (cmp[CMP_ABOVE_140]) begin
			fault_status[BIT_TEMP_FAULT] <= 1'b1;
		end else if (cmp[CMP_BELOW_125]) begin
			fault_status[BIT_TEMP_FAULT] <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_status[BIT_TEMP_WARN] <= STATUS_RESET[BIT_TEMP_WARN];
		end else if (cmp[CMP_ABOVE_100]) begin
			fault_status[BIT_TEMP_WARN] <= 1'b1;
		end else if (cmp[CMP_BELOW_85]) begin
			fault_status[BIT_TEMP_WARN] <= 1'b0;
		end
	end

	// ==========================================
	// Level flags and converter byte
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_status[BIT_CURRENT_HIGH]           <= STATUS_RESET[BIT_CURRENT_HIGH];
			fault_status[BIT_CURRENT_LOW]            <= STATUS_RESET[BIT_CURRENT_LOW];
			fault_status[BIT_SUPPLY_6V]              <= STATUS_RESET[BIT_SUPPLY_6V];
			fault_status[BIT_SUPPLY_12V]             <= STATUS_RESET[BIT_SUPPLY_12V];
			fault_status[ADC_LSB+ADC_W-1:ADC_LSB]    <= STATUS_RESET[ADC_LSB+ADC_W-1:ADC_LSB];
		end else begin
			fault_status[BIT_CURRENT_HIGH]           <= cmp[CMP_CUR_HIGH];
			fault_status[BIT_CURRENT_LOW]            <= cmp[CMP_CUR_LOW];
			fault_status[BIT_SUPPLY_6V]              <= cmp[CMP_SUPPLY_6V];
			fault_status[BIT_SUPPLY_12V]             <= cmp[CMP_SUPPLY_12V];
			fault_status[ADC_LSB+ADC_W-1:ADC_LSB]    <= adc_result;
		end
	end

	// ==========================================
	// Fault pin and alarm current
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_pin <= 1'b0;
		end else begin
			fault_pin <= pin_request(fault_status);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			alarm_force   <= 1'b0;
			alarm_upscale <= 1'b0;
		end else begin
			alarm_force   <= fault_status[BIT_LINK_LOSS] & ~alarm_disable;
			alarm_upscale <= dir_high;
		end
	end

	// ==========================================
	// Published word for the serial side
	// Frozen while a frame is open; the host leaves over five clocks (100 ns) before the first edge
	logic [PUB_W-1:0] published;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			published <= '0;
		end else if (!frame_open) begin
			published <= {~readback_off, fault_status};
		end
	end

	logic frame_rst_n;
	assign frame_rst_n = arst_n & ~sync_n;

	fault_readout u_readout (
		.sclk        (sclk),
		.arst_n      (arst_n),
		.frame_rst_n (frame_rst_n),
		.published   (published),
		.sdo         (sdo),
		.sdo_oe      (sdo_oe),
		.done_toggle (done_toggle)
	);

	// ==========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_link_loss_set: assert property (link_timeout |=> fault_status[BIT_LINK_LOSS] ##1 fault_pin)
		else $error("link loss flag or pin missing");
	a_crc_set: assert property (crc_error |=> fault_status[BIT_CRC_ERROR] ##1 fault_pin)
		else $error("crc flag or pin missing");
	a_alarm_gate: assert property ((fault_status[BIT_LINK_LOSS] && !alarm_disable) |=> alarm_force)
		else $error("alarm current not forced");
	a_alarm_block: assert property (alarm_force |-> $past(fault_status[BIT_LINK_LOSS]) && !$past(alarm_disable))
		else $error("alarm current forced without cause");
	a_alarm_dir: assert property (##4 1'b1 |-> alarm_upscale == $past(alarm_dir_high, 3))
		else $error("alarm direction mismatch");
	a_current_high: assert property (##4 1'b1 |-> fault_status[BIT_CURRENT_HIGH] == $past(comparators[CMP_CUR_HIGH], 3))
		else $error("current high flag mismatch");
	a_current_low: assert property (##4 1'b1 |-> fault_status[BIT_CURRENT_LOW] == $past(comparators[CMP_CUR_LOW], 3))
		else $error("current low flag mismatch");
	a_hot_hold: assert property ((fault_status[BIT_TEMP_FAULT] && !cmp[CMP_BELOW_125]) |=> fault_status[BIT_TEMP_FAULT])
		else $error("temperature fault cleared too early");
	a_warn_hyst: assert property ($fell(fault_status[BIT_TEMP_WARN]) |-> $past(cmp[CMP_BELOW_85]) && !$past(cmp[CMP_ABOVE_100]))
		else $error("warning cleared without cool-down");
	a_supply_6v: assert property (cmp[CMP_SUPPLY_6V] |=> fault_status[BIT_SUPPLY_6V] ##1 fault_pin)
		else $error("6 V flag or pin missing");
	a_supply_12v: assert property (fault_status[BIT_SUPPLY_12V] == $past(cmp[CMP_SUPPLY_12V]))
		else $error("12 V flag mismatch");
	a_adc_byte: assert property (fault_status[ADC_W-1:0] == $past(adc_result))
		else $error("converter byte mismatch");
	a_pin_or: assert property (fault_pin == $past(|(fault_status & PIN_SET_MASK)))
		else $error("fault pin not the OR of pin flags");

	c_link_alarm: cover property (link_timeout ##2 alarm_force);
	c_readout_clear: cover property (fault_status[BIT_CRC_ERROR] ##1 readout_done ##1 !fault_status[BIT_CRC_ERROR]);
	c_hot_cycle: cover property ($rose(fault_status[BIT_TEMP_FAULT]) ##[1:50] $fell(fault_status[BIT_TEMP_FAULT]));
endmodule

// ===== verification/spi_host.sv
// Host-side serial link model that frames, clocks and captures the readout
`timescale 1ns/1ps
module spi_host (
	output logic      sclk,
	output logic      sync_n,
	output logic      sdi,
	input  wire logic sdo,
	input  wire logic sdo_oe
);
	initial begin
		sclk   = 1'b0;
		sync_n = 1'b1;
		sdi    = 1'b0;
	end
	// ==========================================
	// Frame of n edges; sclk stands still outside frames
	task automatic read_frame(input int n, output logic [15:0] word, output logic oe_seen);
		sync_n = 1'b0;
		#100; // Gap lets the published word freeze first
		oe_seen = 1'b0;
		word = 16'h0000;
		for (int i = 0; i < n; i++) begin
			sdi = ~sdi; // Write payload; the block ignores it
			#6 sclk = 1'b1;
			#6 sclk = 1'b0;
			word = {word[14:0], sdo};
			oe_seen = oe_seen | sdo_oe;
		end
		#6 sync_n = 1'b1;
		sdi = 1'b0;
		#100; // Idle gap so the word republishes
	endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the fault status register with a behavioural model
`timescale 1ns/1ps
module tb_top;
	import fault_pkg::*;
	logic                clk            = 1'b0;
	logic                arst_n         = 1'b0;
	logic                link_timeout   = 1'b0;
	logic                crc_error      = 1'b0;
	logic                alarm_disable  = 1'b0;
	logic                readback_off   = 1'b0;
	logic                alarm_dir_high = 1'b0;
	logic [CMP_W-1:0]    comparators    = 8'h00;
	logic [ADC_W-1:0]    adc_result     = 8'h00;
	wire                 sclk, sync_n, sdi, sdo, sdo_oe, fault_pin, alarm_force, alarm_upscale;
	wire [STATUS_W-1:0]  fault_status;
	int                  fail_count     = 0;
	int                  checks_done    = 0;
	logic                tf             = 1'b0;
	logic                tw             = 1'b0;
	logic [1:0]          sticky         = 2'b00;
	logic [15:0]         word, frozen;
	logic                oe;

	always #10 clk = ~clk;

	fault_status_reg u_fault_status_reg (.clk(clk), .arst_n(arst_n), .link_timeout(link_timeout),
		.crc_error(crc_error), .comparators(comparators), .adc_result(adc_result),
		.alarm_disable(alarm_disable), .readback_off(readback_off), .alarm_dir_high(alarm_dir_high),
		.sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .fault_pin(fault_pin),
		.alarm_force(alarm_force), .alarm_upscale(alarm_upscale), .fault_status(fault_status));
	spi_host u_spi_host (.sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

	// ==========================================
	// Model and checking
	function automatic logic [15:0] model();
		return {sticky, comparators[CMP_CUR_HIGH], comparators[CMP_CUR_LOW], tf, tw,
			comparators[CMP_SUPPLY_6V], comparators[CMP_SUPPLY_12V], adc_result};
	endfunction
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic summarize();
		if (fail_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check_all();
		check("fault_status", fault_status, model());
		check("fault_pin", fault_pin, |(model() & PIN_SET_MASK));
		check("alarm_force", alarm_force, sticky[1] & ~alarm_disable);
	endtask

	// Hang guard; a stuck run reports as a failure
	initial begin
		repeat (100000) @(posedge clk);
		fail_count++;
		summarize();
	end

	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'hD1ECDD15));
		step(20);
		check_all();
		arst_n = 1'b1;
		// Random comparator levels, hysteresis held by the model
		for (int i = 0; i < 24; i++) begin
			comparators = CMP_W'($urandom);
			adc_result  = ADC_W'($urandom);
			tf = comparators[CMP_ABOVE_140] ? 1'b1 : (comparators[CMP_BELOW_125] ? 1'b0 : tf);
			tw = comparators[CMP_ABOVE_100] ? 1'b1 : (comparators[CMP_BELOW_85] ? 1'b0 : tw);
			step(6);
			check_all();
		end
		// Event pulses, each alarm mode and direction, then a full readout
		for (int k = 0; k < 4; k++) begin
			alarm_disable  = k[0];
			alarm_dir_high = k[1];
			step(1);
			link_timeout = (k != 3);
			crc_error    = k[1];
			sticky       = {k != 3, k[1]};
			step(1);
			link_timeout = 1'b0;
			crc_error    = 1'b0;
			step(4);
			check_all();
			check("alarm_upscale", alarm_upscale, alarm_dir_high);
			frozen = model();
			u_spi_host.read_frame(16, word, oe);
			check("readout", word, frozen);
			check("sdo_oe", oe, 1'b1);
			step(6);
			sticky = 2'b00;
			check_all();
		end
		// Readout disabled, then a short frame: neither clears the flags
		alarm_disable = 1'b0;
		readback_off  = 1'b1;
		link_timeout  = 1'b1;
		step(1);
		link_timeout = 1'b0;
		sticky       = 2'b10;
		step(4);
		u_spi_host.read_frame(16, word, oe);
		check("sdo_oe", oe, 1'b0);
		step(6);
		check_all();
		readback_off = 1'b0;
		step(3);
		u_spi_host.read_frame(8, word, oe);
		step(6);
		check_all();
		// Reset in mid-run clears everything
		arst_n = 1'b0;
		sticky = 2'b00;
		tf     = 1'b0;
		tw     = 1'b0;
		comparators = 8'h00;
		adc_result  = 8'h00;
		step(2);
		check_all();
		arst_n = 1'b1;
		step(6);
		check_all();
		summarize();
	end
endmodule
